// ===== design/rsc_pkg.sv
// Constants, types and register map of the reset source controller.
//////////////////////////////////////////////////////////////////////
// How it works
// - A master clear input held low produces a system reset together with the rest of the board.
// - The master clear input is glitch filtered, so only low pulses longer than the minimum width reset.
// - A master clear reset sets the external reset flag at bit 7 of the reset control register.
// - The software reset instruction asserts system reset without touching the clock source.
// - After a software reset, system reset is released on the following cycle so fetching restarts.
// - A software reset sets the software reset flag at bit 6 of the reset control register.
// - A watchdog time-out while running asserts system reset at once, with the clock left alone.
// - A watchdog time-out in Sleep or Idle only wakes the processor and never resets it.
// - A watchdog reset sets the watchdog time-out flag at bit 4 of the reset control register.
//////////////////////////////////////////////////////////////////////
package rsc_pkg;

  // Register bus shape
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 16;

  // Register offsets
  localparam logic [REG_ADDR_W-1:0] OFS_RESET_CONTROL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_EVENT_STATUS = 4'h2;
  localparam logic [REG_ADDR_W-1:0] OFS_EVENT_MASK = 4'h4;

  // Reset control register fields
  localparam int EXTERNAL_RESET_BIT = 7;
  localparam int SOFTWARE_RESET_BIT = 6;
  localparam int WATCHDOG_TIMEOUT_BIT = 4;
  localparam logic [REG_DATA_W-1:0] RESET_CONTROL_RESET = 16'h0000;

  // Event status and mask fields
  localparam int EVENT_W = 4;
  localparam int EV_EXTERNAL = 0;
  localparam int EV_SOFTWARE = 1;
  localparam int EV_WATCHDOG = 2;
  localparam int EV_WAKE = 3;
  localparam logic [EVENT_W-1:0] EVENT_RESET = 4'h0;

  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MASTER_CLEAR_INPUT_MIN_WIDTH_NS = 2000;
  localparam int MASTER_CLEAR_INPUT_MIN_CYCLES = (MASTER_CLEAR_INPUT_MIN_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Reset sequencer states
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_EXT = 4'b0010,
    ST_SW = 4'b0100,
    ST_WDT = 4'b1000
  } rsc_state_e;

endpackage

// ===== design/rsc_sync.sv
// Three-stage input synchroniser with agreement on the last two stages.
`timescale 1ns/1ps
module rsc_sync
  import rsc_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Asynchronous input and clean level
  input wire logic asyncIn,
  output logic syncOut
);

  logic stage1Q;
  logic stage2Q;
  logic stage3Q;

  // Shift chain; stage one feeds only stage two
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1Q <= RESET_LEVEL;
      stage2Q <= RESET_LEVEL;
      stage3Q <= RESET_LEVEL;
    end else begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
    end
  end

  // A change counts only once two settled stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncOut <= RESET_LEVEL;
    end else if (stage2Q == stage3Q) begin
      syncOut <= stage3Q;
    end
  end

endmodule

// ===== design/rsc_glitch_filter.sv
// Minimum low-width filter for the synchronised master clear level.
`timescale 1ns/1ps
module rsc_glitch_filter
  import rsc_pkg::*;
#(
  parameter int MIN_CYCLES = MASTER_CLEAR_INPUT_MIN_CYCLES,
  parameter int CNT_W = $clog2(MIN_CYCLES + 2)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Filter path
  input wire logic levelInN,
  output logic lowAccepted
);

  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(MIN_CYCLES);

  logic [CNT_W-1:0] lowCntQ;

  // Count low cycles; any high sample restarts the count
  always_ff @(posedge ref_clk) begin
    if (rst || levelInN) begin
      lowCntQ <= '0;
    end else if (lowCntQ <= CNT_LIMIT) begin
      lowCntQ <= lowCntQ + CNT_W'(1);
    end
  end

  // Strictly longer than the minimum is accepted, release is immediate
  always_ff @(posedge ref_clk) begin
    if (rst || levelInN) begin
      lowAccepted <= 1'b0;
    end else if (lowCntQ >= CNT_LIMIT) begin
      lowAccepted <= 1'b1;
    end
  end

endmodule

// ===== design/rsc_reset_source_control.sv
// Reset source sequencer with cause flags, event status and register port.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module rsc_reset_source_control
  import rsc_pkg::*;
#(
  parameter int MIN_CYCLES = MASTER_CLEAR_INPUT_MIN_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_DATA_W-1:0] regRdData,
  // External pin
  input wire logic masterClearInputN,
  // Core side sources
  input wire logic resetInstruction,
  input wire logic watchdogTimeout,
  input wire logic cpuSleep,
  input wire logic cpuIdle,
  // Results
  output logic systemResetSignal,
  output logic wakeRequest,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////
  // Declarations

  logic masterClearSyncN;
  logic extResetReq;
  logic lowPower;
  logic wdtResetReq;
  logic wdtWakeReq;
  logic stRun;
  logic extEnter;
  logic swEnter;
  logic wdtEnter;
  logic rconWrite;
  logic statusRead;
  logic maskWrite;
  logic [EVENT_W-1:0] eventSet;
  rsc_state_e stateQ;
  rsc_state_e stateD;
  logic [REG_DATA_W-1:0] rconQ;
  logic [REG_DATA_W-1:0] rconSetMask;
  logic [EVENT_W-1:0] statusQ;
  logic [EVENT_W-1:0] maskQ;

  // Address match used by every register access
  function automatic logic hit(input logic [REG_ADDR_W-1:0] a, input logic [REG_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Event field widened into register lane
  function automatic logic [REG_DATA_W-1:0] widen(input logic [EVENT_W-1:0] v);
    widen = {{(REG_DATA_W - EVENT_W){1'b0}}, v};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Master clear conditioning

  // Pin is asynchronous, so it passes three stages first
  rsc_sync #(
    .RESET_LEVEL(1'b1)
  ) uMclrSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn(masterClearInputN),
    .syncOut(masterClearSyncN)
  );

  // Short low pulses never reach the sequencer
  rsc_glitch_filter #(
    .MIN_CYCLES(MIN_CYCLES)
  ) uMclrFilter (
    .ref_clk(ref_clk),
    .rst(rst),
    .levelInN(masterClearSyncN),
    .lowAccepted(extResetReq)
  );

  //////////////////////////////////////////////////////////////////////
  // Source qualification

  // Watchdog splits on power mode: reset when running, wake when asleep
  assign lowPower = cpuSleep | cpuIdle;
  assign wdtResetReq = watchdogTimeout & ~lowPower;
  assign wdtWakeReq = watchdogTimeout & lowPower;
  assign wakeRequest = wdtWakeReq;

  // Entry conditions, external first, then instruction, then watchdog
  assign stRun = (stateQ == ST_RUN);
  assign extEnter = stRun & extResetReq;
  assign swEnter = stRun & ~extResetReq & resetInstruction;
  assign wdtEnter = stRun & ~extResetReq & ~resetInstruction & wdtResetReq;

  //////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state; a valid master clear overrides any short reset state
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_RUN: begin
        if (extEnter) begin
          stateD = ST_EXT;
        end else if (swEnter) begin
          stateD = ST_SW;
        end else if (wdtEnter) begin
          stateD = ST_WDT;
        end
      end
      ST_EXT: begin
        if (!extResetReq) begin
          stateD = ST_RUN;
        end
      end
      ST_SW: begin
        stateD = extResetReq ? ST_EXT : ST_RUN;
      end
      ST_WDT: begin
        stateD = extResetReq ? ST_EXT : ST_RUN;
      end
      default: begin
        stateD = ST_RUN;
      end
    endcase
  end

  // State register; no clock control lives here, so the source is kept
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateQ <= ST_RUN;
    end else begin
      stateQ <= stateD;
    end
  end

  // Watchdog path is combinational so the reset does not wait for an edge
  assign systemResetSignal = ~stRun | wdtResetReq;

  //////////////////////////////////////////////////////////////////////
  // Reset control register

  assign rconWrite = regWr & hit(regAddr, OFS_RESET_CONTROL);

  // Cause bits set on the cycle the reset is entered
  always_comb begin
    rconSetMask = '0;
    rconSetMask[EXTERNAL_RESET_BIT] = extEnter;
    rconSetMask[SOFTWARE_RESET_BIT] = swEnter;
    rconSetMask[WATCHDOG_TIMEOUT_BIT] = wdtEnter;
  end

  // Flags ignore system reset; a write of zero clears, a set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rconQ <= RESET_CONTROL_RESET;
    end else if (rconWrite) begin
      rconQ <= (rconQ & regWrData) | rconSetMask;
    end else begin
      rconQ <= rconQ | rconSetMask;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt

  assign statusRead = regRd & hit(regAddr, OFS_EVENT_STATUS);
  assign maskWrite = regWr & hit(regAddr, OFS_EVENT_MASK);

  // Event vector
  always_comb begin
    eventSet = '0;
    eventSet[EV_EXTERNAL] = extEnter;
    eventSet[EV_SOFTWARE] = swEnter;
    eventSet[EV_WATCHDOG] = wdtEnter;
    eventSet[EV_WAKE] = wdtWakeReq;
  end

  // Sticky status, read clears, a same-cycle event survives the read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      statusQ <= EVENT_RESET;
    end else if (statusRead) begin
      statusQ <= eventSet;
    end else begin
      statusQ <= statusQ | eventSet;
    end
  end

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      maskQ <= EVENT_RESET;
    end else if (maskWrite) begin
      maskQ <= regWrData[EVENT_W-1:0];
    end
  end

  // Level interrupt from registered state only
  assign irq = |(statusQ & maskQ);

  //////////////////////////////////////////////////////////////////////
  // Read port

  // Data stand for one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (!regRd) begin
      regRdData <= '0;
    end else if (hit(regAddr, OFS_RESET_CONTROL)) begin
      regRdData <= rconQ;
    end else if (hit(regAddr, OFS_EVENT_STATUS)) begin
      regRdData <= widen(statusQ);
    end else if (hit(regAddr, OFS_EVENT_MASK)) begin
      regRdData <= widen(maskQ);
    end else begin
      regRdData <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Helper: length of the current low run on the clean pin level
  logic [15:0] lowRunQ;
  always_ff @(posedge ref_clk) begin
    if (rst || masterClearSyncN) begin
      lowRunQ <= '0;
    end else if (lowRunQ != 16'hffff) begin
      lowRunQ <= lowRunQ + 16'h0001;
    end
  end

  // Software reset entry and the cycle that follows it
  sequence swTaken;
    swEnter;
  endsequence

  sequence swQuiet;
    swTaken ##1 !extResetReq;
  endsequence

  // Watchdog in a low power mode with nothing else pending
  sequence wdtAsleep;
    wdtWakeReq && stRun && !extResetReq && !resetInstruction;
  endsequence

  a_master_clear_input_reset_out: assert property (extResetReq |-> ##1 systemResetSignal)
    else $error("master clear did not hold system reset");

  a_glitch_min_width: assert property ($rose(extResetReq) |-> lowRunQ > 16'(MIN_CYCLES))
    else $error("master clear accepted too early");

  a_ext_flag_set: assert property (extEnter |=> rconQ[EXTERNAL_RESET_BIT] && stateQ == ST_EXT)
    else $error("external reset flag not set");

  a_sw_reset_assert: assert property (swTaken |=> systemResetSignal && stateQ == ST_SW)
    else $error("software reset not asserted");

  a_sw_reset_release: assert property (swQuiet |=> stateQ == ST_RUN)
    else $error("software reset not released next cycle");

  a_sw_flag_set: assert property (swTaken |=> rconQ[SOFTWARE_RESET_BIT])
    else $error("software reset flag not set");

  a_wdt_async_reset: assert property (wdtResetReq |-> systemResetSignal)
    else $error("watchdog reset not immediate");

  a_wdt_wake_only: assert property (wdtAsleep |-> wakeRequest ##1 stateQ == ST_RUN)
    else $error("watchdog in low power caused a reset");

  a_wdt_flag_set: assert property (wdtEnter |=> rconQ[WATCHDOG_TIMEOUT_BIT] && stateQ == ST_WDT)
    else $error("watchdog flag not set");

  a_flag_clear_cause: assert property ($fell(rconQ[EXTERNAL_RESET_BIT]) |-> $past(rconWrite))
    else $error("external flag cleared without a write");

  a_flag_hold_reset: assert property (rconQ[SOFTWARE_RESET_BIT] && !rconWrite |=> rconQ[SOFTWARE_RESET_BIT])
    else $error("software flag lost");

  a_irq_status_tie: assert property (statusQ[EV_WAKE] && maskQ[EV_WAKE] |-> irq)
    else $error("unmasked wake event without interrupt");

endmodule

// ===== sim/rsc_supervisor_model.sv
// Board supervisory circuit model that drives the master clear pin.
`timescale 1ns/1ps
module rsc_supervisor_model (
  // Clock
  input wire logic ref_clk,
  // Pin
  output logic masterClearInputN
);
  // The pin has no internal pull-up, so the board drives it high when idle
  initial masterClearInputN = 1'b1;

  // Hold the pin low for n whole cycles, changing only after an edge
  task automatic hold_low(input int n);
    @(posedge ref_clk);
    masterClearInputN <= 1'b0;
    repeat (n) @(posedge ref_clk);
    masterClearInputN <= 1'b1;
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the reset source controller.
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  // Short filter keeps the master clear tests brief
  localparam int MINC = 4;
  typedef struct packed {
    logic inst;
    logic wdt;
    logic sleep;
    logic idle;
    logic rstNow;
    logic rstNext;
    logic wake;
    logic [15:0] reset_control_register;
    logic [15:0] stat;
  } rsc_row_s;
  logic ref_clk = 1'b0;
  logic rst;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [REG_DATA_W-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [REG_DATA_W-1:0] regRdData;
  logic masterClearInputN;
  logic resetInstruction;
  logic watchdogTimeout;
  logic cpuSleep;
  logic cpuIdle;
  logic systemResetSignal;
  logic wakeRequest;
  logic irq;
  int nErrors = 0;
  int checksDone = 0;
  int hits;
  rsc_row_s r;
  // Instruction, running watchdog, watchdog in sleep and idle, both at once
  rsc_row_s rows [5] = '{
    '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0040, 16'h0002},
    '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0010, 16'h0004},
    '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0008},
    '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0008},
    '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0040, 16'h0002}
  };

  //////////////////////////////////////////////////////////////////////
  // Clock, design and pin driver
  always #12.5 ref_clk = ~ref_clk;

  rsc_reset_source_control #(.MIN_CYCLES(MINC)) rsc_reset_source_control_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .masterClearInputN(masterClearInputN), .resetInstruction(resetInstruction),
    .watchdogTimeout(watchdogTimeout), .cpuSleep(cpuSleep), .cpuIdle(cpuIdle),
    .systemResetSignal(systemResetSignal), .wakeRequest(wakeRequest), .irq(irq)
  );

  rsc_supervisor_model rsc_supervisor_model_inst (
    .ref_clk(ref_clk),
    .masterClearInputN(masterClearInputN)
  );

  //////////////////////////////////////////////////////////////////////
  // Shared compare and bus tasks; bus tasks start off the edge
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge ref_clk);
    #1 chk(regRdData, 16'h0000);
  endtask

  // Samples this many cycles and counts those with system reset high
  task automatic countHigh(input int n);
    hits = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1 if (systemResetSignal === 1'b1) hits++;
    end
  endtask

  task automatic closeOut();
    $display("Counts: checks=%0d mismatches=%0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    resetInstruction = 1'b0;
    watchdogTimeout = 1'b0;
    cpuSleep = 1'b0;
    cpuIdle = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk(systemResetSignal, 1'b0);
    rdChk(OFS_RESET_CONTROL, RESET_CONTROL_RESET);
    rdChk(OFS_EVENT_STATUS, 16'h0000);
    rdChk(OFS_EVENT_MASK, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rdChk(4'h6, 16'h0000);
    wr(OFS_EVENT_MASK, 16'h000F);
    rdChk(OFS_EVENT_MASK, 16'h000F);
    $display("test register reset and map done");

    // Table of core side events
    foreach (rows[i]) begin
      r = rows[i];
      resetInstruction <= r.inst;
      watchdogTimeout <= r.wdt;
      cpuSleep <= r.sleep;
      cpuIdle <= r.idle;
      // Same-cycle outputs are looked at before the edge that moves the state
      #1 chk(systemResetSignal, r.rstNow);
      chk(wakeRequest, r.wake);
      @(posedge ref_clk);
      resetInstruction <= 1'b0;
      watchdogTimeout <= 1'b0;
      #1 chk(systemResetSignal, r.rstNext);
      @(posedge ref_clk);
      #1 chk(systemResetSignal, 1'b0);
      chk(irq, 1'b1);
      cpuSleep <= 1'b0;
      cpuIdle <= 1'b0;
      rdChk(OFS_RESET_CONTROL, r.reset_control_register);
      rdChk(OFS_EVENT_STATUS, r.stat);
      #1 chk(irq, 1'b0);
      wr(OFS_RESET_CONTROL, 16'hFFFF);
      rdChk(OFS_RESET_CONTROL, r.reset_control_register);
      wr(OFS_RESET_CONTROL, 16'h0000);
      rdChk(OFS_RESET_CONTROL, 16'h0000);
      $display("test event row %0d done", i);
    end

    // Masked event holds irq low until the mask opens
    wr(OFS_EVENT_MASK, 16'h0000);
    resetInstruction <= 1'b1;
    @(posedge ref_clk);
    resetInstruction <= 1'b0;
    @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    wr(OFS_EVENT_MASK, 16'h0002);
    #1 chk(irq, 1'b1);
    rdChk(OFS_EVENT_STATUS, 16'h0002);
    #1 chk(irq, 1'b0);
    wr(OFS_RESET_CONTROL, 16'h0000);
    $display("test interrupt mask done");

    // Short low pulse on the pin is filtered out
    rsc_supervisor_model_inst.hold_low(3);
    countHigh(20);
    chk(hits[15:0], 16'h0000);
    rdChk(OFS_RESET_CONTROL, 16'h0000);
    $display("test short pin pulse done");

    // Long low pulse resets for about its length, then releases
    fork
      rsc_supervisor_model_inst.hold_low(30);
    join_none
    countHigh(60);
    chk(16'((hits >= 20) && (hits <= 30)), 16'h0001);
    chk(systemResetSignal, 1'b0);
    rdChk(OFS_RESET_CONTROL, 16'h0080);
    rdChk(OFS_EVENT_STATUS, 16'h0001);
    $display("test long pin pulse done");
    closeOut();
  end
endmodule
